// ---- hw/can_tx_buffer_ordering.sv ----
// Function
// - Same ID dedicated buffers pending at one pick: lowest number first
// - One mask write requests many buffers
// - Queue put index: lowest free slot
// - Queue order follows message ID, then slot number, at each pick; frames already in the output FIFO keep their order
`timescale 1ns/10ps
`default_nettype none
`include "can_tx_order_defines.svh"
module can_tx_buffer_ordering
  import can_tx_order_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    sys_rst_i,
  // Add request, one bit per buffer
  input  wire logic                    tx_buffer_add_request_i,
  input  wire logic [`NUM_BUFS-1:0]    tx_buffer_add_mask_i,
  // Identifier held in each buffer, flattened
  input  wire logic [`NUM_BUFS*`MSG_ID_W-1:0] buf_msg_id_i,
  // Queue slot allocation
  input  wire logic                    queue_put_i,
  output logic      [`BUF_IDX_W-1:0]   queue_put_index_o,
  output logic                         queue_full_o,
  // Status
  output logic      [`NUM_BUFS-1:0]    pending_o,
  // Selected buffer toward the CAN engine
  output logic                         sel_valid_o,
  input  wire logic                    sel_ready_i,
  output logic      [`BUF_IDX_W-1:0]   sel_index_o
);
  // ==========================================================
  // Pending requests
  logic [`NUM_BUFS-1:0] pending;
  logic [`NUM_BUFS-1:0] queue_used;
  logic                 fifo_in_ready;
  logic [`BUF_IDX_W-1:0] win_idx;
  logic                 win_any;
  arb_state_e           state;
  wire                  launch = (state == ARB_PICK) && win_any && fifo_in_ready;
  wire [`NUM_BUFS-1:0]  add_bits = tx_buffer_add_request_i ? tx_buffer_add_mask_i : `MASK_ZERO;
  wire [`NUM_BUFS-1:0]  clr_bits = launch ? (`NUM_BUFS'(1) << win_idx) : `MASK_ZERO;
  wire [`NUM_BUFS-1:0]  next_pending = (pending & ~clr_bits) | add_bits;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) pending <= `MASK_ZERO;
    else pending <= next_pending;
  end
  assign pending_o = pending;

  // ==========================================================
  // Arbitration: lowest ID, ties to lowest buffer number
  // Scan whole set each pick; new requests never jump a decided frame.
  logic [`MSG_ID_W-1:0]  best_id  [`NUM_BUFS+1];
  logic [`BUF_IDX_W-1:0] best_idx [`NUM_BUFS+1];
  logic                  best_vld [`NUM_BUFS+1];
  assign best_id[0]  = '1;
  assign best_idx[0] = '0;
  assign best_vld[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < `NUM_BUFS; g++) begin : g_arb
      wire [`MSG_ID_W-1:0] id_g = buf_msg_id_i[g*`MSG_ID_W +: `MSG_ID_W];
      // Strict less keeps earlier buffer on equal ID
      wire take = pending[g] && (!best_vld[g] || (id_g < best_id[g]));
      assign best_id[g+1]  = take ? id_g : best_id[g];
      assign best_idx[g+1] = take ? `BUF_IDX_W'(g) : best_idx[g];
      assign best_vld[g+1] = best_vld[g] | take;
      // A lower pending buffer may never lose to an equal ID
      a_tie_order: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        launch && pending[g] && (`BUF_IDX_W'(g) < win_idx)
        |-> (id_g > best_id[`NUM_BUFS]))
        else $error("lower buffer lost arbitration");
    end
  endgenerate
  assign win_idx = best_idx[`NUM_BUFS];
  assign win_any = best_vld[`NUM_BUFS];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) state <= ARB_IDLE;
    else begin
      case (state)
        ARB_IDLE: state <= ARB_PICK;
        ARB_PICK: if (launch) state <= ARB_BUSY;
        ARB_BUSY: state <= ARB_PICK;
        default:  state <= ARB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Queue put index: lowest free slot, not cyclic
  logic [`BUF_IDX_W-1:0] free_idx [`NUM_Q_BUFS+1];
  logic                  free_vld [`NUM_Q_BUFS+1];
  assign free_idx[`NUM_Q_BUFS] = '0;
  assign free_vld[`NUM_Q_BUFS] = 1'b0;
  generate
    for (g = 0; g < `NUM_Q_BUFS; g++) begin : g_free
      wire slot_free = !queue_used[`Q_BASE + g] && !pending[`Q_BASE + g];
      assign free_idx[g] = slot_free ? `BUF_IDX_W'(`Q_BASE + g) : free_idx[g+1];
      assign free_vld[g] = slot_free | free_vld[g+1];
      a_free_lower: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        slot_free |-> (free_idx[0] <= `BUF_IDX_W'(`Q_BASE + g)))
        else $error("put index above a free slot");
    end
  endgenerate
  assign queue_full_o = !free_vld[0];
  wire [`NUM_BUFS-1:0] put_bits = (queue_put_i && free_vld[0]) ? (`NUM_BUFS'(1) << free_idx[0]) : `MASK_ZERO;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) queue_used <= `MASK_ZERO;
    else queue_used <= (queue_used | put_bits) & ~clr_bits;
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) queue_put_index_o <= `Q_BASE;
    else queue_put_index_o <= free_idx[0];
  end

  // ==========================================================
  // Output buffering toward the engine
  tx_out_fifo #(
    .WIDTH (`BUF_IDX_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (launch),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (win_idx),
    .out_valid_o (sel_valid_o),
    .out_ready_i (sel_ready_i),
    .out_data_o  (sel_index_o)
  );

  // ==========================================================
  // Checks
  // Request bookkeeping
  a_launch_clears: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    launch && !add_bits[win_idx]
    |=> !pending[$past(win_idx)])
    else $error("launched buffer still pending");

  a_add_sets: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    tx_buffer_add_request_i
    |=> ((pending & $past(tx_buffer_add_mask_i)) == $past(tx_buffer_add_mask_i)))
    else $error("add request bits not pending");

  a_pend_hold: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !tx_buffer_add_request_i && !launch
    |=> (pending == $past(pending)))
    else $error("pending bits moved without cause");

  // Arbitration outcome
  a_winner_pending: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    launch |-> pending[win_idx])
    else $error("winner not pending");

  a_lower_no_tie: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    launch && win_idx != 0
    |-> !(pending[0] && buf_msg_id_i[`MSG_ID_W-1:0] <= best_id[`NUM_BUFS]))
    else $error("lower buffer with same or lower id skipped");

  a_no_spurious: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (pending == `MASK_ZERO) |-> !launch)
    else $error("launch without request");

  a_busy_gap: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    launch |=> state == ARB_BUSY ##1 state == ARB_PICK)
    else $error("pick spacing broken");

  // Engine side: a full FIFO must hold the arbiter back
  a_fifo_stall: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !fifo_in_ready |-> !launch)
    else $error("launch while fifo full");

  a_sel_stands: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    sel_valid_o && !sel_ready_i
    |=> sel_valid_o && $stable(sel_index_o))
    else $error("chosen buffer dropped before accept");

  // Queue slot allocation
  a_put_lowest: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !queue_full_o && !queue_used[`Q_BASE] && !pending[`Q_BASE]
    |-> free_idx[0] == `Q_BASE)
    else $error("put index not lowest free slot");

  a_put_takes: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    queue_put_i && !queue_full_o
    |=> queue_used[$past(free_idx[0])])
    else $error("put did not claim the free slot");

  a_full_refuse: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    queue_put_i && queue_full_o
    |=> ((queue_used & ~$past(queue_used)) == `MASK_ZERO))
    else $error("put accepted while queue full");

  // Reset leaves nothing pending and the put index on the first slot
  a_reset_state: assert property (
    @(posedge ref_clk_i)
    sys_rst_i
    |=> (pending == `MASK_ZERO) && !sel_valid_o && (queue_put_index_o == `Q_BASE))
    else $error("state not cleared by reset");

  c_group_add: cover property (
    @(posedge ref_clk_i) tx_buffer_add_request_i && $countones(tx_buffer_add_mask_i) > 1);
  c_launch: cover property (
    @(posedge ref_clk_i) launch ##2 launch);
  c_queue_full: cover property (
    @(posedge ref_clk_i) queue_full_o);
  c_fifo_full: cover property (
    @(posedge ref_clk_i) !fifo_in_ready);
  c_high_win: cover property (
    @(posedge ref_clk_i) launch && win_idx != 0 && pending[0]);
endmodule : can_tx_buffer_ordering
`default_nettype wire

// ---- hw/can_tx_order_defines.svh ----
`ifndef CAN_TX_ORDER_DEFINES_SVH
`define CAN_TX_ORDER_DEFINES_SVH
`define NUM_DED_BUFS   4
`define NUM_Q_BUFS     4
`define NUM_BUFS       8
`define BUF_IDX_W      3
`define MSG_ID_W       11
`define FIFO_DEPTH     4
`define FIFO_PTR_W     2
`define Q_BASE         3'h4
`define MASK_ZERO      8'h00
`endif

// ---- hw/can_tx_order_pkg.sv ----
package can_tx_order_pkg;
  `include "can_tx_order_defines.svh"
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_PICK,
    ARB_BUSY
  } arb_state_e;
endpackage : can_tx_order_pkg

// ---- hw/tx_out_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module tx_out_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              do_wr = in_valid_i && in_ready_o;
  wire              do_rd = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) wr_ptr <= PW'((wr_ptr + 1'b1) % DEPTH);
      if (do_rd) rd_ptr <= PW'((rd_ptr + 1'b1) % DEPTH);
      count <= count + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (do_wr) mem[wr_ptr] <= in_data_i;
  end
endmodule : tx_out_fifo
`default_nettype wire

// ---- dv/can_engine_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module can_engine_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Chosen buffer stream
  input  wire logic       sel_valid_i,
  input  wire logic [2:0] sel_index_i,
  output logic            sel_ready_o,
  // Bus busy with other nodes
  input  wire logic       stall_i
);
  // A long foreign frame holds the engine off the stream
  // Strict order only through this in-order stream
  assign sel_ready_o = !stall_i;
endmodule : can_engine_model
`default_nettype wire

// ---- dv/can_tx_buffer_ordering_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "can_tx_order_defines.svh"
module can_tx_buffer_ordering_test;
  import can_tx_order_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic add_req = 1'b0;
  logic [7:0] add_mask = 8'h00;
  logic [`NUM_BUFS*`MSG_ID_W-1:0] ids = '0;
  logic put = 1'b0;
  logic stall = 1'b0;
  logic [2:0] put_idx;
  logic [2:0] sel_index;
  logic sel_valid;
  logic sel_ready;
  logic [7:0] pend;
  logic qfull;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  can_tx_buffer_ordering u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .tx_buffer_add_request_i(add_req), .tx_buffer_add_mask_i(add_mask), .buf_msg_id_i(ids),
    .queue_put_i(put), .queue_put_index_o(put_idx), .queue_full_o(qfull), .pending_o(pend),
    .sel_valid_o(sel_valid), .sel_ready_i(sel_ready), .sel_index_o(sel_index));
  can_engine_model u_engine (.ref_clk_i(ref_clk_i), .sel_valid_i(sel_valid),
    .sel_index_i(sel_index), .sel_ready_o(sel_ready), .stall_i(stall));
  // ==========================================
  // Helpers
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t index %0d expected %0d", $time, got, exp);
    end
  endtask : check
  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t bits %0h expected %0h", $time, got, exp);
    end
  endtask : check_bits
  task automatic check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t flag %0b expected %0b", $time, got, exp);
    end
  endtask : check_flag
  task automatic add(input logic [7:0] m);
    @(posedge ref_clk_i) add_req <= 1'b1;
    add_mask <= m;
    @(posedge ref_clk_i) add_req <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    stall <= 1'b0;
    #1;
  endtask : add
  task automatic take(input logic [2:0] exp);
    int n;
    n = 0;
    while (!(sel_valid === 1'b1 && sel_ready === 1'b1) && n < 50) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("CHECK FAILED %0t no buffer offered", $time);
    end
    check(sel_index, exp);
    @(posedge ref_clk_i);
    #1;
  endtask : take
  task automatic qput(input logic [2:0] exp);
    check(put_idx, exp);
    @(posedge ref_clk_i) put <= 1'b1;
    @(posedge ref_clk_i) put <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : qput
  // ==========================================
  // Scenarios
  task automatic t_queue;
    qput(3'h4);
    qput(3'h5);
    @(posedge ref_clk_i) ids[4*11+:11] <= 11'h050;
    ids[5*11+:11] <= 11'h050;
    stall <= 1'b1;
    add(8'h30);
    take(3'h4);
    take(3'h5);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(put_idx, 3'h4);
    check_flag(qfull, 1'b0);
  endtask : t_queue
  task automatic t_serial;
    int seq;
    seq = 0;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk_i) stall <= 1'b1;
      add(8'h01);
      take(3'h0);
      seq++;
    end
    check_bits(8'(seq), 8'h03);
    check_bits(pend, 8'h00);
  endtask : t_serial
  task automatic t_full;
    qput(3'h4);
    qput(3'h5);
    qput(3'h6);
    qput(3'h7);
    check_flag(qfull, 1'b1);
  endtask : t_full
  task automatic t_same_id;
    @(posedge ref_clk_i) stall <= 1'b1;
    for (int n = 0; n < 4; n++) ids[n*11+:11] <= 11'h123;
    // One grouped request, nothing earlier pending
    add(8'h0f);
    for (int n = 0; n < 4; n++) take(n[2:0]);
  endtask : t_same_id
  task automatic t_prio;
    @(posedge ref_clk_i) stall <= 1'b1;
    ids[0+:44] <= {11'h7ff, 11'h200, 11'h100, 11'h300};
    add(8'h0f);
    take(3'h1);
    take(3'h2);
    take(3'h0);
    take(3'h3);
  endtask : t_prio
  // ==========================================
  // Main sequence and watchdog
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    t_queue();
    t_same_id();
    t_prio();
    t_serial();
    t_full();
    finish_test();
  end
endmodule : can_tx_buffer_ordering_test
`default_nettype wire
